// ===== redriver_map.svh
// Register offsets, reset values and fixed codes of the config bank.
// Assumes a 32-bit Wishbone slave with byte-addressed word offsets.
`ifndef REDRIVER_MAP_SVH
`define REDRIVER_MAP_SVH

// Byte indexes, byte address is index times four
`define RDC_IDX_RSVD0 4'h0
`define RDC_IDX_RSVD1 4'h1
`define RDC_IDX_PDOWN 4'h2
`define RDC_IDX_LANE0 4'h3
`define RDC_IDX_LANE3 4'h6
`define RDC_IDX_RSVD7 4'h7
`define RDC_IDX_STATUS 4'h8
`define RDC_IDX_LAST 4'h8

// Field positions
`define RDC_PDOWN_LSB 4
`define RDC_EQ_LSB 4
`define RDC_FG_LSB 2
`define RDC_SW_LSB 0

// Reset values
`define RDC_BYTE_RST 8'h00
`define RDC_RDATA_RST 32'h0000_0000

// Fixed upper serial address bits
`define RDC_ADDR_HI 3'h7

// Synchroniser depth
`define RDC_SYNC_STAGES 2

`endif

// ===== redriver_pkg.sv
// Types shared by the redriver configuration bank.
// Assumes redriver_map.svh supplies the numeric constants.
package redriver_pkg;

    // Settings of one lane
    typedef struct packed {
        logic [3:0] eq;
        logic [1:0] fg;
        logic [1:0] sw;
    } lane_cfg_s;

    // Synchronised strap levels
    typedef struct packed {
        logic host_config_select;
        logic cable_absent;
        logic [3:0] boost_select;
        logic gain_hi_or_cfg_clear_n;
        logic gain_lo_select;
        logic [1:0] swing_select;
        logic [3:0] addr_select;
    } strap_s;

    // Configuration source
    typedef enum logic [2:0] {
        MODE_PIN = 3'b001,
        MODE_LOAD = 3'b010,
        MODE_HOST = 3'b100
    } mode_e;

endpackage

// ===== strap_sync.sv
// Two-flop synchroniser for a bundle of strap levels.
// Assumes the straps are quasi-static board levels.
`timescale 1ns/1ns
`include "redriver_map.svh"

module strap_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Levels
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // First stage feeds only the second
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= level_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign level_o = stage2_reg;

endmodule // strap_sync

// ===== redriver_config_select.sv
// Configuration select and register bank of a four-lane redriver.
// Assumes a classic Wishbone master and static board straps.
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "redriver_map.svh"

module redriver_config_select #(
    parameter int LANES = 4
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Board straps
    input wire logic host_config_select_i,
    input wire logic cable_absent_i,
    input wire logic [3:0] boost_select_i,
    input wire logic gain_hi_or_cfg_clear_n_i,
    input wire logic gain_lo_select_i,
    input wire logic [1:0] swing_select_i,
    input wire logic [3:0] addr_select_i,
    // Lane settings
    output redriver_pkg::lane_cfg_s [LANES-1:0] lane_cfg_o,
    output logic [LANES-1:0] lane_power_down_o,
    output logic low_power_o,
    output logic [6:0] device_addr_o
);

    ////////////////////////////////////////////////////////////////////////
    // Strap synchronisation

    localparam int STRAP_W = $bits(redriver_pkg::strap_s);

    redriver_pkg::strap_s strap_raw;
    redriver_pkg::strap_s strap;
    logic [STRAP_W-1:0] strap_level;

    assign strap_raw = '{
        host_config_select: host_config_select_i,
        cable_absent: cable_absent_i,
        boost_select: boost_select_i,
        gain_hi_or_cfg_clear_n: gain_hi_or_cfg_clear_n_i,
        gain_lo_select: gain_lo_select_i,
        swing_select: swing_select_i,
        addr_select: addr_select_i
    };

    strap_sync #(
        .WIDTH(STRAP_W)
    ) u_strap_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .level_i(strap_raw),
        .level_o(strap_level)
    );

    assign strap = redriver_pkg::strap_s'(strap_level);

    ////////////////////////////////////////////////////////////////////////
    // Strap-derived common lane setting

    redriver_pkg::lane_cfg_s strap_cfg;

    always_comb begin
        strap_cfg.eq = strap.boost_select;
        strap_cfg.fg = {strap.gain_hi_or_cfg_clear_n,
                        strap.gain_lo_select};
        strap_cfg.sw = strap.swing_select;
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine

    redriver_pkg::mode_e mode_reg;
    redriver_pkg::mode_e mode_next;

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            redriver_pkg::MODE_PIN: begin
                if (strap.host_config_select) begin
                    mode_next = redriver_pkg::MODE_LOAD;
                end
            end
            redriver_pkg::MODE_LOAD: begin
                if (strap.host_config_select) begin
                    mode_next = redriver_pkg::MODE_HOST;
                end else begin
                    mode_next = redriver_pkg::MODE_PIN;
                end
            end
            redriver_pkg::MODE_HOST: begin
                if (!strap.host_config_select) begin
                    mode_next = redriver_pkg::MODE_PIN;
                end
            end
            default: begin
                mode_next = redriver_pkg::MODE_PIN;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mode_reg <= redriver_pkg::MODE_PIN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic bus_req;
    logic wr_take;
    logic [3:0] byte_idx;
    logic idx_mapped;
    logic cfg_clear;

    // Word index of a byte address, unmapped beyond the last
    function automatic logic [3:0] word_index(input logic [7:0] adr);
        word_index = adr[5:2];
    endfunction

    function automatic logic index_ok(input logic [7:0] adr);
        index_ok = (adr[7:6] == 2'h0) && (adr[1:0] == 2'h0) &&
                   (adr[5:2] <= `RDC_IDX_LAST);
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i;
    assign byte_idx = word_index(wb_adr_i);
    assign idx_mapped = index_ok(wb_adr_i);
    // Write lands on the edge the master sees ack
    assign wr_take = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0] &&
                     idx_mapped;
    assign cfg_clear = (mode_reg == redriver_pkg::MODE_HOST) &&
                       !strap.gain_hi_or_cfg_clear_n;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration bytes

    logic [7:0] pdown_reg;
    logic [7:0] rsvd7_reg;
    redriver_pkg::lane_cfg_s [LANES-1:0] lane_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || cfg_clear) begin
            pdown_reg <= `RDC_BYTE_RST;
            rsvd7_reg <= `RDC_BYTE_RST;
        end else if (wr_take) begin
            if (byte_idx == `RDC_IDX_PDOWN) begin
                pdown_reg <= wb_dat_i[7:0];
            end
            if (byte_idx == `RDC_IDX_RSVD7) begin
                rsvd7_reg <= wb_dat_i[7:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge clk_sys_i) begin
                if (!rst_n_i || cfg_clear) begin
                    lane_reg[g] <= `RDC_BYTE_RST;
                end else if (mode_reg == redriver_pkg::MODE_LOAD) begin
                    lane_reg[g] <= strap_cfg;
                end else if (wr_take &&
                             byte_idx == `RDC_IDX_LANE0 + 4'(g)) begin
                    lane_reg[g] <= wb_dat_i[7:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = `RDC_RDATA_RST;
        if (idx_mapped) begin
            unique case (byte_idx)
                `RDC_IDX_PDOWN: rdata_next[7:0] = pdown_reg;
                `RDC_IDX_RSVD7: rdata_next[7:0] = rsvd7_reg;
                `RDC_IDX_STATUS: begin
                    rdata_next[2:0] = mode_reg;
                    rdata_next[3] = strap.cable_absent;
                    rdata_next[7:4] = strap.addr_select;
                end
                default: begin
                    if (byte_idx >= `RDC_IDX_LANE0 &&
                        byte_idx <= `RDC_IDX_LANE3) begin
                        rdata_next[7:0] =
                            lane_reg[2'(byte_idx - `RDC_IDX_LANE0)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wb_dat_o <= `RDC_RDATA_RST;
        end else if (bus_req && !wb_ack_o) begin
            wb_dat_o <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lane outputs

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            lane_cfg_o <= '0;
            lane_power_down_o <= '0;
        end else if (mode_reg == redriver_pkg::MODE_HOST) begin
            lane_cfg_o <= lane_reg;
            lane_power_down_o <= pdown_reg[`RDC_PDOWN_LSB +: LANES];
        end else begin
            lane_cfg_o <= {LANES{strap_cfg}};
            lane_power_down_o <= '0;
        end
    end

    // Low power follows cable absent in every mode
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            low_power_o <= 1'b0;
        end else begin
            low_power_o <= strap.cable_absent;
        end
    end

    // Serial address: fixed upper bits over strap bits
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            device_addr_o <= {`RDC_ADDR_HI, 4'h0};
        end else begin
            device_addr_o <= {`RDC_ADDR_HI, strap.addr_select};
        end
    end

endmodule // redriver_config_select

// ===== redriver_config_select_props.sv
// Concurrent checks on the configuration bank ports.
// Assumes it is bound into redriver_config_select.
`timescale 1ns/1ns
`include "redriver_map.svh"

module redriver_config_select_props #(
    parameter int LANES = 4
) (
    // Clock, reset and bus handshake
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Straps
    input wire logic host_config_select_i,
    input wire logic cable_absent_i,
    input wire logic [3:0] boost_select_i,
    input wire logic gain_hi_or_cfg_clear_n_i,
    input wire logic gain_lo_select_i,
    input wire logic [1:0] swing_select_i,
    input wire logic [3:0] addr_select_i,
    // Lane side
    input wire redriver_pkg::lane_cfg_s [LANES-1:0] lane_cfg_o,
    input wire logic [LANES-1:0] lane_power_down_o,
    input wire logic low_power_o,
    input wire logic [6:0] device_addr_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic [2:0] up_cnt_reg;
    logic up;
    logic host;
    logic [7:0] strap_cfg;
    assign up = (up_cnt_reg == 3'h7);
    assign host = host_config_select_i && gain_hi_or_cfg_clear_n_i;
    assign strap_cfg = {boost_select_i, gain_hi_or_cfg_clear_n_i,
                        gain_lo_select_i, swing_select_i};

    // Cycles since reset release, saturating
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) up_cnt_reg <= 3'h0;
        else if (!up) up_cnt_reg <= up_cnt_reg + 3'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence straps_still;
        host && $stable(strap_cfg);
    endsequence

    a_pin_lanes: assert property ((up && !host_config_select_i)[*6] |->
        lane_cfg_o[0] == $past(strap_cfg, 3) &&
        lane_cfg_o[LANES-1] == $past(strap_cfg, 3))
        else $error("lane settings differ from straps");
    a_power_track: assert property (up |->
        low_power_o == $past(cable_absent_i, 3))
        else $error("low power does not follow cable input");
    a_addr_straps: assert property (up |->
        device_addr_o == {`RDC_ADDR_HI, $past(addr_select_i, 3)})
        else $error("device address wrong");
    a_ack_pulse: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");
    a_ack_cause: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_load_straps: assert property (up && !host_config_select_i ##1
        straps_still[*6] |-> lane_cfg_o[LANES-1] == strap_cfg)
        else $error("register mode not loaded from straps");
    a_host_hold: assert property ((up && host && !wb_ack_o)[*8] |->
        $stable(lane_cfg_o) && $stable(lane_power_down_o))
        else $error("register values changed without write");
    a_clear_bank: assert property ((up && host_config_select_i &&
        !gain_hi_or_cfg_clear_n_i)[*8] |-> lane_cfg_o == '0 &&
        lane_power_down_o == '0)
        else $error("register clear not applied");
endmodule // redriver_config_select_props

bind redriver_config_select redriver_config_select_props #(
    .LANES(LANES)
) props_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .host_config_select_i(host_config_select_i),
    .cable_absent_i(cable_absent_i), .boost_select_i(boost_select_i),
    .gain_hi_or_cfg_clear_n_i(gain_hi_or_cfg_clear_n_i),
    .gain_lo_select_i(gain_lo_select_i), .swing_select_i(swing_select_i),
    .addr_select_i(addr_select_i), .lane_cfg_o(lane_cfg_o),
    .lane_power_down_o(lane_power_down_o), .low_power_o(low_power_o),
    .device_addr_o(device_addr_o)
);

// ===== strap_board.sv
// Board strap model: driven levels, or pull-ups once released.
// Assumes the bench changes requests just after rising edges.
`timescale 1ns/1ns

module strap_board (
    // Request from the bench
    input wire logic drive_i,
    input wire redriver_pkg::strap_s level_i,
    // Strap pins
    output redriver_pkg::strap_s pins_o
);
    // Every strap has a pull-up
    assign pins_o = drive_i ? level_i : '1;
endmodule // strap_board

// ===== tb.sv
// Self-checking bench for the redriver configuration bank.
// Assumes the strap model and checker are compiled before it.
`timescale 1ns/1ns

module tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic drive = 1'b0;
    redriver_pkg::strap_s lvl = '0;
    redriver_pkg::strap_s pins;
    redriver_pkg::lane_cfg_s [3:0] lane;
    logic [31:0] rdat;
    logic [3:0] pdown;
    logic low_power;
    logic ack;
    logic [6:0] dev_addr;
    logic [7:0] tbl [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
    int err_total = 0;
    int checks = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    strap_board model (.drive_i(drive), .level_i(lvl), .pins_o(pins));

    redriver_config_select #(.LANES(4)) DUT (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
        .host_config_select_i(pins.host_config_select),
        .cable_absent_i(pins.cable_absent),
        .boost_select_i(pins.boost_select),
        .gain_hi_or_cfg_clear_n_i(pins.gain_hi_or_cfg_clear_n),
        .gain_lo_select_i(pins.gain_lo_select),
        .swing_select_i(pins.swing_select), .addr_select_i(pins.addr_select),
        .lane_cfg_o(lane), .lane_power_down_o(pdown),
        .low_power_o(low_power), .device_addr_o(dev_addr)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
        int n;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= 32'(d);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat[7:0];
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk_sys_i);
        if (n >= 16) begin
            err_total++;
            results();
        end
    endtask

    task automatic straps(input logic [13:0] v, input int n);
        lvl <= v;
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic lanes(input logic [7:0] e);
        for (int i = 0; i < 4; i++) chk("lane", 32'(e), 32'(lane[i]));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_pin(input logic [13:0] v);
        straps(v, 6);
        lanes({lvl.boost_select, lvl.gain_hi_or_cfg_clear_n,
               lvl.gain_lo_select, lvl.swing_select});
        chk("low_power", 32'(lvl.cable_absent), 32'(low_power));
        chk("dev_addr", 32'({3'h7, lvl.addr_select}), 32'(dev_addr));
    endtask

    task automatic t_host();
        logic [7:0] q;
        straps(14'h13E0, 6);
        straps(14'h33E0, 8);
        lanes(8'h3E);
        wb(1'b0, 8'h20, 8'h00, q);
        chk("status", 32'h0C, 32'(q));
        wb(1'b1, 8'h1C, 8'hA5, q);
        wb(1'b0, 8'h1C, 8'h00, q);
        chk("spare", 32'hA5, 32'(q));
        chk("low_power", 32'h1, 32'(low_power));
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, 8'(4 * i), i < 3 ? 8'hFF : tbl[i - 3], q);
        end
        wb(1'b1, 8'h40, 8'hFF, q);
        wb(1'b1, 8'h08, 8'h50, q);
        wb(1'b0, 8'h00, 8'h00, q);
        chk("byte0", 32'h0, 32'(q));
        wb(1'b0, 8'h40, 8'h00, q);
        chk("unmapped", 32'h0, 32'(q));
        straps(14'h3FFF, 8);
        for (int i = 0; i < 4; i++) begin
            chk("lane", 32'(tbl[i]), 32'(lane[i]));
            wb(1'b0, 8'(12 + 4 * i), 8'h00, q);
            chk("rd", 32'(tbl[i]), 32'(q));
        end
        chk("pdown", 32'h5, 32'(pdown));
    endtask

    task automatic t_clear();
        logic [7:0] q;
        straps(14'h3F7F, 8);
        lanes(8'h00);
        chk("pdown", 32'h0, 32'(pdown));
        wb(1'b0, 8'h0C, 8'h00, q);
        chk("rd", 32'h0, 32'(q));
        straps(14'h3FFF, 4);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        drive <= 1'b1;
        t_pin(14'h1A95);
        t_pin(14'h056A);
        t_host();
        t_clear();
        t_pin(14'h1A95);
        results();
    end
endmodule // tb
